// >>> verilog/rsdr_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Calibration display page two shows the high pass trim result in bits 7 to 4.
// - Calibration display page two shows the low pass trim result in bits 3 to 0.
// - Converter display page zero shows the 8-bit converter result of the selected input.
// - A conversion starts only on the trigger command and its result is shown 20 us later.
// - Converter display page one bit 7 is 0 for a crystal and 1 for a grounded oscillator input.
// - Converter display page one bits 2 to 0 show the supply voltage setting in use.
// - Converter display page one bits 6 to 3 read as zero.
// - Status bit 6 is set when a range selection command finishes and raises an interrupt.
// - Status bit 5 is set when a supply level command finishes and raises an interrupt.
// - Status bit 4 is set when filter calibration finishes and raises an interrupt.
// - Status bit 3 is set when the conversion finishes and raises an interrupt.
// - Status bit 2 reads 1 while anti-collision support is on.
// - Status bit 1 shows the gain-leveling state set by the on and off commands.
// - Status bit 0 shows auxiliary synthesizer selection set by the hop commands.
// - A read-only register returns a fixed device version number.
module rsdr_status_regs
   import rsdr_pkg::*;
#(
   parameter logic [7:0] DEVICE_VERSION = 8'h5a // Arbitrary value
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] highpass_trim_result,
   input wire logic [3:0] lowpass_trim_result,
   input wire logic [2:0] supply_voltage_setting,
   input wire logic osci_grounded,
   input wire logic anticollision_support_on,
   input wire logic vco_range_done,
   input wire logic supply_level_done,
   input wire logic filter_cal_done,
   input wire logic [7:0] converter_sample,
   output logic direct_cmd_strobe,
   output logic [7:0] direct_cmd_code,
   output logic converter_start,
   output logic [3:0] converter_input_select,
   output logic gain_leveling_on,
   output logic aux_synth_selected,
   output logic cmd_event_irq
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic ready_reg;
   logic [31:0] rdata_reg;
   logic slverr_reg;
   logic [7:0] page_ctrl_reg;
   logic cmd_strobe_reg;
   logic [7:0] cmd_code_reg;
   logic agl_reg;
   logic aux_reg;
   logic irq_reg;
   logic osc_sync1_reg;
   logic osc_sync2_reg;
   rsdr_adc_state_t adc_state_reg;
   rsdr_adc_state_t adc_state_next;
   logic [11:0] adc_cnt_reg;
   logic [11:0] adc_cnt_next;
   logic [7:0] adc_result_reg;
   logic adc_start_reg;

   logic access;
   logic setup_done;
   logic rd_take;
   logic wr_fire;
   logic hit_filt;
   logic hit_conv;
   logic hit_stat;
   logic hit_ver;
   logic hit_ctrl;
   logic hit_cmd;
   logic hit_disp;
   logic addr_ok;
   logic [1:0] calib_display_page_select;
   logic [1:0] converter_display_page_select;
   logic [7:0] filt_disp;
   logic [7:0] conv_disp;
   logic [7:0] stat_disp;
   logic [7:0] rd_byte;
   logic cmd_wr;
   logic [7:0] cmd_val;
   logic adc_trig;
   logic adc_finish;
   logic [NUM_DONE-1:0] done_set;
   logic [NUM_DONE-1:0] done_clr;
   logic [NUM_DONE-1:0] done_flag;
   logic [NUM_DONE-1:0] done_rise;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   assign access = psel & penable;
   assign setup_done = access & ~ready_reg;
   assign rd_take = setup_done & ~pwrite;
   assign wr_fire = access & ready_reg & pwrite & addr_ok;
   assign hit_filt = (paddr == ADDR_FILT_CAL);
   assign hit_conv = (paddr == ADDR_CONV_DISP);
   assign hit_stat = (paddr == ADDR_CMD_STATUS);
   assign hit_ver = (paddr == ADDR_VERSION);
   assign hit_ctrl = (paddr == ADDR_PAGE_CTRL);
   assign hit_cmd = (paddr == ADDR_DIRECT_CMD);
   assign hit_disp = hit_filt | hit_conv | hit_stat | hit_ver;
   assign addr_ok = hit_disp | hit_ctrl | hit_cmd;

   assign calib_display_page_select = page_ctrl_reg[CAL_PAGE_LSB +: 2];
   assign converter_display_page_select = page_ctrl_reg[CONV_PAGE_LSB +: 2];

   // ------------------------------------------------------------
   // Display contents
   // ------------------------------------------------------------
   assign filt_disp = (calib_display_page_select == PAGE_2) ?
      {highpass_trim_result, lowpass_trim_result} : 8'h00;

   assign conv_disp = (converter_display_page_select == PAGE_0) ? adc_result_reg :
      (converter_display_page_select == PAGE_1) ?
      {osc_sync2_reg, 4'h0, supply_voltage_setting} : 8'h00;

   assign stat_disp = {1'b0, done_flag, anticollision_support_on, agl_reg, aux_reg};

   assign rd_byte = hit_filt ? filt_disp :
      hit_conv ? conv_disp :
      hit_stat ? stat_disp :
      hit_ver ? DEVICE_VERSION :
      hit_ctrl ? page_ctrl_reg : 8'h00;

   // ------------------------------------------------------------
   // APB answer, one wait state
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         slverr_reg <= 1'b0;
      end else begin
         ready_reg <= setup_done;
         if (setup_done) begin
            rdata_reg <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            slverr_reg <= ~addr_ok;
         end
      end
   end

   assign prdata = rdata_reg;
   assign pready = ready_reg;
   assign pslverr = slverr_reg;

   // ------------------------------------------------------------
   // Page control; display addresses take no write
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_ctrl_reg <= PAGE_CTRL_RST;
      end else if (wr_fire & hit_ctrl) begin
         page_ctrl_reg <= pwdata[7:0];
      end
   end

   assign converter_input_select = page_ctrl_reg[INSEL_LSB +: 4];

   // ------------------------------------------------------------
   // Direct commands
   // ------------------------------------------------------------
   assign cmd_wr = wr_fire & hit_cmd;
   assign cmd_val = pwdata[7:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_strobe_reg <= 1'b0;
         cmd_code_reg <= 8'h00;
      end else begin
         cmd_strobe_reg <= cmd_wr;
         if (cmd_wr) begin
            cmd_code_reg <= cmd_val;
         end
      end
   end

   assign direct_cmd_strobe = cmd_strobe_reg;
   assign direct_cmd_code = cmd_code_reg;

   // Gain leveling and synthesizer selection follow their commands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         agl_reg <= 1'b0;
         aux_reg <= 1'b0;
      end else if (cmd_wr) begin
         if (cmd_val == CMD_AGL_ON) begin
            agl_reg <= 1'b1;
         end else if (cmd_val == CMD_AGL_OFF) begin
            agl_reg <= 1'b0;
         end
         if (cmd_val == CMD_HOP_AUX) begin
            aux_reg <= 1'b1;
         end else if (cmd_val == CMD_HOP_MAIN) begin
            aux_reg <= 1'b0;
         end
      end
   end

   assign gain_leveling_on = agl_reg;
   assign aux_synth_selected = aux_reg;

   // ------------------------------------------------------------
   // Oscillator mode pin synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_sync1_reg <= 1'b0;
         osc_sync2_reg <= 1'b0;
      end else begin
         osc_sync1_reg <= osci_grounded;
         osc_sync2_reg <= osc_sync1_reg;
      end
   end

   // ------------------------------------------------------------
   // Converter sequencing
   // ------------------------------------------------------------
   // A trigger during a running conversion is ignored
   assign adc_trig = cmd_wr & (cmd_val == CMD_ADC_TRIG) & (adc_state_reg == ADC_IDLE);
   assign adc_finish = (adc_state_reg == ADC_BUSY) & (adc_cnt_reg == ADC_LAST);

   always_comb begin
      adc_state_next = adc_state_reg;
      adc_cnt_next = adc_cnt_reg;
      case (adc_state_reg)
         ADC_IDLE: begin
            adc_cnt_next = ADC_CNT_RST;
            if (adc_trig) begin
               adc_state_next = ADC_BUSY;
            end
         end
         ADC_BUSY: begin
            if (adc_finish) begin
               adc_state_next = ADC_IDLE;
               adc_cnt_next = ADC_CNT_RST;
            end else begin
               adc_cnt_next = adc_cnt_reg + 12'h001;
            end
         end
         default: begin
            adc_state_next = ADC_IDLE;
            adc_cnt_next = ADC_CNT_RST;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_state_reg <= ADC_IDLE;
         adc_cnt_reg <= ADC_CNT_RST;
         adc_start_reg <= 1'b0;
         adc_result_reg <= 8'h00;
      end else begin
         adc_state_reg <= adc_state_next;
         adc_cnt_reg <= adc_cnt_next;
         adc_start_reg <= adc_trig;
         if (adc_finish) begin
            adc_result_reg <= converter_sample;
         end
      end
   end

   assign converter_start = adc_start_reg;

   // ------------------------------------------------------------
   // Completion flags and interrupt event
   // ------------------------------------------------------------
   assign done_set[DONE_ADC] = adc_finish;
   assign done_set[DONE_FCAL] = filter_cal_done;
   assign done_set[DONE_SUPP] = supply_level_done;
   assign done_set[DONE_VCO] = vco_range_done;
   assign done_clr[DONE_ADC] = adc_trig;
   assign done_clr[DONE_FCAL] = cmd_wr & (cmd_val == CMD_FILT_CAL);
   assign done_clr[DONE_SUPP] = cmd_wr & ((cmd_val == CMD_SUPP_AUTO) | (cmd_val == CMD_SUPP_MAN));
   assign done_clr[DONE_VCO] = cmd_wr & ((cmd_val == CMD_VCO_AUTO) | (cmd_val == CMD_VCO_MAN));

   genvar gi;
   generate
      for (gi = 0; gi < NUM_DONE; gi = gi + 1) begin : g_done
         rsdr_done_flag u_flag (
            .pclk(pclk),
            .presetn(presetn),
            .set_evt(done_set[gi]),
            .clr_evt(done_clr[gi]),
            .flag(done_flag[gi]),
            .rise(done_rise[gi])
         );
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |done_rise;
      end
   end

   assign cmd_event_irq = irq_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_highpass_page: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_take & hit_filt & (calib_display_page_select == PAGE_2))
      |=> (prdata[7:4] == $past(highpass_trim_result)))
      else $error("high pass trim not shown on page two");

   chk_lowpass_page: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_take & hit_filt & (calib_display_page_select == PAGE_2))
      |=> (prdata[3:0] == $past(lowpass_trim_result)) && pready)
      else $error("low pass trim not shown on page two");

   chk_adc_capture: assert property (@(posedge pclk) disable iff (!presetn)
      adc_finish |=> (adc_result_reg == $past(converter_sample)) && cmd_event_irq)
      else $error("converter result not captured");

   chk_adc_settle: assert property (@(posedge pclk) disable iff (!presetn)
      converter_start |-> (adc_cnt_reg == ADC_CNT_RST) && !adc_finish
      ##1 (adc_state_reg == ADC_BUSY) [*8])
      else $error("conversion ended too early");

   chk_adc_trigger: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(adc_state_reg == ADC_BUSY) |-> $past(cmd_wr && (cmd_val == CMD_ADC_TRIG)))
      else $error("conversion started without trigger command");

   chk_osc_mode: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_take & hit_conv & (converter_display_page_select == PAGE_1))
      |=> (prdata[7] == $past(osc_sync2_reg)) && (prdata[2:0] == $past(supply_voltage_setting)))
      else $error("oscillator or supply page wrong");

   chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_take & hit_conv & (converter_display_page_select == PAGE_1))
      |=> (prdata[6:3] == 4'h0))
      else $error("reserved bits not zero");

   chk_agl_follow: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_wr & (cmd_val == CMD_AGL_ON)) |=> gain_leveling_on ##1 gain_leveling_on)
      else $error("gain leveling not enabled by command");

   chk_version_read: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_take & hit_ver) |=> (prdata == {24'h00_0000, DEVICE_VERSION}) && !pslverr)
      else $error("version register wrong");

   chk_display_ro: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_fire & hit_disp) |=> $stable(page_ctrl_reg) && !direct_cmd_strobe)
      else $error("display write had an effect");

endmodule // rsdr_status_regs
`default_nettype wire

// >>> verilog/rsdr_pkg.sv
`default_nettype none
package rsdr_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_FILT_CAL = 8'h2c;
   localparam logic [7:0] IDX_CONV_DISP = 8'h2d;
   localparam logic [7:0] IDX_CMD_STATUS = 8'h2e;
   localparam logic [7:0] IDX_VERSION = 8'h33;
   localparam logic [7:0] IDX_PAGE_CTRL = 8'h3a;
   localparam logic [7:0] IDX_DIRECT_CMD = 8'h3b;

   localparam logic [11:0] ADDR_FILT_CAL = {2'b00, IDX_FILT_CAL, 2'b00};
   localparam logic [11:0] ADDR_CONV_DISP = {2'b00, IDX_CONV_DISP, 2'b00};
   localparam logic [11:0] ADDR_CMD_STATUS = {2'b00, IDX_CMD_STATUS, 2'b00};
   localparam logic [11:0] ADDR_VERSION = {2'b00, IDX_VERSION, 2'b00};
   localparam logic [11:0] ADDR_PAGE_CTRL = {2'b00, IDX_PAGE_CTRL, 2'b00};
   localparam logic [11:0] ADDR_DIRECT_CMD = {2'b00, IDX_DIRECT_CMD, 2'b00};

   // ------------------------------------------------------------
   // Page control fields and reset value
   // ------------------------------------------------------------
   localparam int CAL_PAGE_LSB = 0;
   localparam int CONV_PAGE_LSB = 2;
   localparam int INSEL_LSB = 4;
   localparam logic [7:0] PAGE_CTRL_RST = 8'h00;
   localparam logic [1:0] PAGE_0 = 2'b00;
   localparam logic [1:0] PAGE_1 = 2'b01;
   localparam logic [1:0] PAGE_2 = 2'b10;

   // ------------------------------------------------------------
   // Direct command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_HOP_MAIN = 8'h84;
   localparam logic [7:0] CMD_HOP_AUX = 8'h85;
   localparam logic [7:0] CMD_ADC_TRIG = 8'h87;
   localparam logic [7:0] CMD_FILT_CAL = 8'h88;
   localparam logic [7:0] CMD_SUPP_AUTO = 8'ha2;
   localparam logic [7:0] CMD_SUPP_MAN = 8'ha3;
   localparam logic [7:0] CMD_VCO_AUTO = 8'ha4;
   localparam logic [7:0] CMD_VCO_MAN = 8'ha5;
   localparam logic [7:0] CMD_AGL_ON = 8'ha6;
   localparam logic [7:0] CMD_AGL_OFF = 8'ha7;

   // ------------------------------------------------------------
   // Completion flags, index into the done vector
   // ------------------------------------------------------------
   localparam int NUM_DONE = 4;
   localparam int DONE_ADC = 0;
   localparam int DONE_FCAL = 1;
   localparam int DONE_SUPP = 2;
   localparam int DONE_VCO = 3;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int ADC_SETTLE_NS = 20000;
   localparam int ADC_SETTLE_CYC = (ADC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] ADC_LAST = 12'(ADC_SETTLE_CYC - 1);
   localparam logic [11:0] ADC_CNT_RST = 12'h000;

   typedef enum logic [1:0] {
      ADC_IDLE = 2'b01,
      ADC_BUSY = 2'b10
   } rsdr_adc_state_t;

endpackage
`default_nettype wire

// >>> verilog/rsdr_done_flag.sv
`timescale 1ns/1ps
`default_nettype none
module rsdr_done_flag
   import rsdr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic set_evt,
   input wire logic clr_evt,
   output logic flag,
   output logic rise
);

   logic flag_reg;

   // Set wins over clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_reg <= 1'b0;
      end else if (set_evt) begin
         flag_reg <= 1'b1;
      end else if (clr_evt) begin
         flag_reg <= 1'b0;
      end
   end

   assign flag = flag_reg;
   assign rise = set_evt & ~flag_reg;

   chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      set_evt |=> flag_reg)
      else $error("done flag lost its set event");

endmodule // rsdr_done_flag
`default_nettype wire

// >>> tb/rsdr_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Analog front end: finishes commands and feeds the converter
// ------------------------------------------------------------
module rsdr_analog_model
   import rsdr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic direct_cmd_strobe,
   input wire logic [7:0] direct_cmd_code,
   input wire logic [3:0] converter_input_select,
   output logic vco_range_done,
   output logic supply_level_done,
   output logic filter_cal_done,
   output logic [7:0] converter_sample
);
   logic [7:0] code_reg;
   logic [3:0] wait_reg;
   // Level depends on the chosen source, so a wrong select shows in the result
   assign converter_sample = {converter_input_select, ~converter_input_select};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_reg <= 8'h00;
         wait_reg <= 4'h0;
         vco_range_done <= 1'b0;
         supply_level_done <= 1'b0;
         filter_cal_done <= 1'b0;
      end else begin
         vco_range_done <= 1'b0;
         supply_level_done <= 1'b0;
         filter_cal_done <= 1'b0;
         if (direct_cmd_strobe) begin
            code_reg <= direct_cmd_code;
            wait_reg <= 4'h6;
         end else if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
            if (wait_reg == 4'h1) begin
               vco_range_done <= code_reg == CMD_VCO_AUTO || code_reg == CMD_VCO_MAN;
               supply_level_done <= code_reg == CMD_SUPP_AUTO || code_reg == CMD_SUPP_MAN;
               filter_cal_done <= code_reg == CMD_FILT_CAL;
            end
         end
      end
   end
endmodule // rsdr_analog_model
`default_nettype wire

// >>> tb/tb_reader_status_display_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_reader_status_display_regs
   import rsdr_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_data;
   logic [3:0] hp, lp, insel;
   logic [2:0] supply;
   logic osci, ac_on, vco_d, supp_d, fcal_d, strobe, conv_start, agl, aux, irq, rd_err;
   logic [7:0] sample, code;
   int err_count = 0;
   int n_checks = 0;
   int irq_seen = 0;
   int k;
   rsdr_status_regs i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .highpass_trim_result(hp), .lowpass_trim_result(lp),
      .supply_voltage_setting(supply), .osci_grounded(osci), .anticollision_support_on(ac_on),
      .vco_range_done(vco_d), .supply_level_done(supp_d), .filter_cal_done(fcal_d),
      .converter_sample(sample), .direct_cmd_strobe(strobe), .direct_cmd_code(code),
      .converter_start(conv_start), .converter_input_select(insel), .gain_leveling_on(agl),
      .aux_synth_selected(aux), .cmd_event_irq(irq));
   rsdr_analog_model i_afe (.pclk(pclk), .presetn(presetn), .direct_cmd_strobe(strobe),
      .direct_cmd_code(code), .converter_input_select(insel), .vco_range_done(vco_d),
      .supply_level_done(supp_d), .filter_cal_done(fcal_d), .converter_sample(sample));
   // ------------------------------------------------------------
   // Clock, reset, watchdog
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (irq === 1'b1) irq_seen++;
   end
   initial begin
      #400000;
      err_count++;
      close_out();
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_count++;
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 8'h00);
      chk(rd_data, exp);
      chk_bit(rd_err, 1'b0);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_ident();
      rd_chk(ADDR_VERSION, 32'h0000005a);
      apb(ADDR_VERSION, 1'b1, 8'hff);
      rd_chk(ADDR_VERSION, 32'h0000005a);
      rd_chk(ADDR_CMD_STATUS, 32'h00000000);
      apb(12'h000, 1'b0, 8'h00);
      chk_bit(rd_err, 1'b1);
   endtask
   task automatic t_calib();
      apb(ADDR_PAGE_CTRL, 1'b1, {6'h00, PAGE_2});
      rd_chk(ADDR_FILT_CAL, 32'h000000c3);
      apb(ADDR_FILT_CAL, 1'b1, 8'h11);
      hp <= 4'h0;
      lp <= 4'hf;
      rd_chk(ADDR_FILT_CAL, 32'h0000000f);
      apb(ADDR_PAGE_CTRL, 1'b1, {6'h00, PAGE_0});
      rd_chk(ADDR_FILT_CAL, 32'h00000000);
   endtask
   task automatic t_osc();
      apb(ADDR_PAGE_CTRL, 1'b1, {4'h0, PAGE_1, 2'b00});
      for (k = 0; k < 8; k++) begin
         supply <= 3'(k);
         osci <= k[0];
         repeat (3) @(posedge pclk);
         rd_chk(ADDR_CONV_DISP, {24'h0, k[0], 4'h0, 3'(k)});
      end
   endtask
   task automatic t_conv();
      apb(ADDR_PAGE_CTRL, 1'b1, {4'h9, PAGE_0, 2'b00});
      apb(ADDR_DIRECT_CMD, 1'b1, CMD_ADC_TRIG);
      @(posedge pclk);
      chk_bit(conv_start, 1'b1);
      rd_chk(ADDR_CONV_DISP, 32'h00000000);
      rd_chk(ADDR_CMD_STATUS, 32'h00000000);
      k = irq_seen;
      repeat (2500) @(posedge pclk);
      rd_chk(ADDR_CONV_DISP, 32'h00000096);
      rd_chk(ADDR_CMD_STATUS, 32'h00000008);
      chk(irq_seen, k + 1);
   endtask
   task automatic t_done();
      logic [7:0] cmds [5] = '{CMD_VCO_AUTO, CMD_SUPP_MAN, CMD_FILT_CAL,
         CMD_VCO_MAN, CMD_SUPP_AUTO};
      logic [7:0] mid [5] = '{8'h08, 8'h48, 8'h68, 8'h38, 8'h58};
      logic [7:0] bits [5] = '{8'h48, 8'h68, 8'h78, 8'h78, 8'h78};
      int base;
      for (k = 0; k < 5; k++) begin
         base = irq_seen;
         apb(ADDR_DIRECT_CMD, 1'b1, cmds[k]);
         // Reissuing a command clears its flag until the new finish
         rd_chk(ADDR_CMD_STATUS, {24'h0, mid[k]});
         repeat (12) @(posedge pclk);
         rd_chk(ADDR_CMD_STATUS, {24'h0, bits[k]});
         chk(irq_seen, base + 1);
      end
   endtask
   task automatic t_mode();
      ac_on <= 1'b1;
      apb(ADDR_DIRECT_CMD, 1'b1, CMD_AGL_ON);
      apb(ADDR_DIRECT_CMD, 1'b1, CMD_HOP_AUX);
      rd_chk(ADDR_CMD_STATUS, 32'h0000007f);
      chk_bit(agl & aux, 1'b1);
      ac_on <= 1'b0;
      apb(ADDR_DIRECT_CMD, 1'b1, CMD_AGL_OFF);
      apb(ADDR_DIRECT_CMD, 1'b1, CMD_HOP_MAIN);
      rd_chk(ADDR_CMD_STATUS, 32'h00000078);
   endtask
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      hp = 4'hc;
      lp = 4'h3;
      supply = 3'h0;
      osci = 1'b0;
      ac_on = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_ident();
      t_calib();
      t_osc();
      t_conv();
      t_done();
      t_mode();
      close_out();
   end
endmodule // tb_reader_status_display_regs
`default_nettype wire
